// ---- src/tcc_pkg.sv ----
// Package of constants and carriers for the timer channel control block
package tcc_pkg;

   // ==========================================================
   // Register map (byte offsets on the plain register port)
   localparam logic [3:0] OFF_CCR    = 4'h0; // counter clock/clear control
   localparam logic [3:0] OFF_PIN    = 4'h1; // compare/capture pin control
   localparam logic [3:0] OFF_GRA    = 4'h2; // first general register
   localparam logic [3:0] OFF_GRB    = 4'h4; // second general register
   localparam logic [3:0] OFF_CNT    = 4'h6; // channel counter
   localparam logic [3:0] OFF_STAT   = 4'h8; // event status, read only
   localparam logic [3:0] OFF_CLR    = 4'h9; // event clear, write only
   localparam logic [3:0] OFF_IEN    = 4'ha; // event interrupt enable
   localparam logic [3:0] OFF_MODE   = 4'hb; // phase/pwm/sync mode bits

   // ==========================================================
   // Reset values and fixed bits
   localparam logic [7:0]  CCR_RESET  = 8'h80;
   localparam logic [7:0]  PIN_RESET  = 8'h88;
   localparam logic [7:0]  CCR_FIXED  = 8'h80; // reserved bits read as 1
   localparam logic [7:0]  PIN_FIXED  = 8'h88;
   localparam logic [15:0] GR_RESET   = 16'hffff;
   localparam logic [15:0] CNT_RESET  = 16'h0000;

   // ==========================================================
   // Field positions
   localparam int CLR_LSB  = 5;  // clear select, bits 6:5
   localparam int EDGE_LSB = 3;  // external edge select, bits 4:3
   localparam int PSC_LSB  = 0;  // prescale select, bits 2:0
   localparam int FB_LSB   = 4;  // second register function, bits 6:4
   localparam int FA_LSB   = 0;  // first register function, bits 2:0
   localparam int MODE_PHASE = 0;
   localparam int MODE_PWM   = 1;
   localparam int MODE_SYNC  = 2;

   // ==========================================================
   // Encodings
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A    = 2'h1;
   localparam logic [1:0] CLR_B    = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] OUT_NONE = 2'h0;
   localparam logic [1:0] OUT_LOW  = 2'h1;
   localparam logic [1:0] OUT_HIGH = 2'h2;
   localparam logic [1:0] OUT_TGL  = 2'h3;
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   localparam int         DIV_BITS = 3;   // divider for clk/2, /4, /8

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcc_bus_t;

endpackage

// ---- src/tcc_channel.sv ----
// Timer channel with clock source, clear and compare/capture pin control
//
// Function
// R1 - Five identical channels; channel 2 phase exception
// R2 - Clock/clear control resets to 0x80
// R3 - Reserved bits unwritable, read as one
// R4 - Clear field: none, first, second, sync
// R5 - Clear on match or on capture
// R6 - External edge: rising, falling, both
// R7 - Prescale: clk, /2, /4, /8, pins A-D
// R8 - Internal falling edges; external per edge field
// R9 - Channel 2 phase mode overrides clock settings
// R10 - Pin control resets to 0x88
// R11 - Second register function decode
// R12 - First register same decode, drives first pin
// R13 - Compare outputs low until first match
// R14 - Channel 2 toggle becomes drive high
// R15 - Channels 3,4 ignore pin control in PWM
// R16 - Compare continuously, flag on equality
// R17 - Capture counter on edge, flag too
// R18 - Sync clear from group, same cycle
`timescale 1ns/100ps
module tcc_channel #(
   parameter int CHANNEL = 0                 // 0..4, see R1
) (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        STANDBY,
   // Register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   // External clock pins and phase inputs
   input  wire logic [3:0]  EXT_CLK,
   input  wire logic        PHASE_UP,
   input  wire logic        PHASE_DOWN,
   // Sync group
   input  wire logic        SYNC_CLEAR_IN,
   output logic             SYNC_CLEAR_OUT,
   // Compare/capture pins
   input  wire logic        PIN_A_IN,
   output logic             PIN_A_OUT,
   output logic             PIN_A_OE_N,
   input  wire logic        PIN_B_IN,
   output logic             PIN_B_OUT,
   output logic             PIN_B_OE_N,
   // Interrupt
   output logic             IRQ
);

   // =========================================================
   // Register bus decode
   tcc_pkg::tcc_bus_t bus;
   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction

   wire wr_ccr  = bus.wr & hit(bus.addr, tcc_pkg::OFF_CCR);
   wire wr_pin  = bus.wr & hit(bus.addr, tcc_pkg::OFF_PIN);
   wire wr_gral = bus.wr & hit(bus.addr, tcc_pkg::OFF_GRA);
   wire wr_grah = bus.wr & hit(bus.addr, tcc_pkg::OFF_GRA + 4'h1);
   wire wr_grbl = bus.wr & hit(bus.addr, tcc_pkg::OFF_GRB);
   wire wr_grbh = bus.wr & hit(bus.addr, tcc_pkg::OFF_GRB + 4'h1);
   wire wr_cntl = bus.wr & hit(bus.addr, tcc_pkg::OFF_CNT);
   wire wr_cnth = bus.wr & hit(bus.addr, tcc_pkg::OFF_CNT + 4'h1);
   wire wr_clr  = bus.wr & hit(bus.addr, tcc_pkg::OFF_CLR);
   wire wr_ien  = bus.wr & hit(bus.addr, tcc_pkg::OFF_IEN);
   wire wr_mode = bus.wr & hit(bus.addr, tcc_pkg::OFF_MODE);

   // Reset and standby both initialise the channel, except read data, which only reset clears
   wire init = ~RST_N | STANDBY;

   // =========================================================
   // Registers
   logic [7:0]  ccr_q, pin_q;
   logic [15:0] gra_q, grb_q, cnt_q;
   logic [1:0]  stat_q, ien_q;
   logic [2:0]  mode_q;
   logic [7:0]  rdata_q;

   // Control registers; reserved bits forced on write
   always_ff @(posedge CLOCK) begin
      if (init) begin
         ccr_q <= tcc_pkg::CCR_RESET;                 // see R2
         pin_q <= tcc_pkg::PIN_RESET;                 // see R10
      end else begin
         if (wr_ccr)
            ccr_q <= WDATA | tcc_pkg::CCR_FIXED;      // see R3
         if (wr_pin)
            pin_q <= WDATA | tcc_pkg::PIN_FIXED;      // see R3
      end
   end

   // Mode bits only meaningful where the channel supports them
   always_ff @(posedge CLOCK) begin
      if (init)
         mode_q <= 3'h0;
      else if (wr_mode)
         mode_q <= WDATA[2:0];
   end

   wire phase_mode = (CHANNEL == 2) & mode_q[tcc_pkg::MODE_PHASE];
   wire pwm_mode   = (CHANNEL >= 3) & mode_q[tcc_pkg::MODE_PWM];
   wire sync_en    = mode_q[tcc_pkg::MODE_SYNC];

   // =========================================================
   // Field decode
   wire [1:0] clr_sel  = ccr_q[tcc_pkg::CLR_LSB +: 2];
   wire [1:0] edge_sel = ccr_q[tcc_pkg::EDGE_LSB +: 2];
   wire [2:0] psc_sel  = ccr_q[tcc_pkg::PSC_LSB +: 3];
   // Complementary/reset-sync PWM overrides pin control
   wire [2:0] func_a = pwm_mode ? 3'h0
                                : pin_q[tcc_pkg::FA_LSB +: 3]; // see R15
   wire [2:0] func_b = pwm_mode ? 3'h0
                                : pin_q[tcc_pkg::FB_LSB +: 3]; // see R15
   wire cap_a = func_a[2];                            // see R12
   wire cap_b = func_b[2];                            // see R11

   // =========================================================
   // Prescaler: free divider, falling edge of each divided clock
   logic [tcc_pkg::DIV_BITS-1:0] div_q;
   always_ff @(posedge CLOCK) begin
      if (init)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   // Divided clock k is div_q[k-1]; falling edge = all low bits wrap
   logic [3:0] int_tick;
   assign int_tick[0] = 1'b1;                          // see R8
   genvar gk;
   generate
      for (gk = 1; gk < 4; gk++) begin : g_div
         assign int_tick[gk] = &div_q[gk-1:0];         // see R8
      end
   endgenerate

   // External pins: edge detect on registered copies
   logic [3:0] ext_q;
   always_ff @(posedge CLOCK) begin
      if (init)
         ext_q <= 4'h0;
      else
         ext_q <= EXT_CLK;
   end

   wire [3:0] ext_rise = EXT_CLK & ~ext_q;
   wire [3:0] ext_fall = ~EXT_CLK & ext_q;
   wire       sel_rise = ext_rise[psc_sel[1:0]];
   wire       sel_fall = ext_fall[psc_sel[1:0]];
   wire       ext_tick = (edge_sel == tcc_pkg::EDGE_RISE) ? sel_rise :
                         (edge_sel == tcc_pkg::EDGE_FALL) ? sel_fall :
                         (sel_rise | sel_fall);        // see R6
   wire       src_tick = psc_sel[2] ? ext_tick
                                    : int_tick[psc_sel[1:0]]; // see R7

   // =========================================================
   // Compare and capture events
   logic pa_q, pb_q;
   always_ff @(posedge CLOCK) begin
      if (init) begin
         pa_q <= 1'b0;
         pb_q <= 1'b0;
      end else begin
         pa_q <= PIN_A_IN;
         pb_q <= PIN_B_IN;
      end
   end

   function automatic logic cap_edge(input logic [1:0] f,
                                     input logic now, input logic was);
      cap_edge = (f == tcc_pkg::CAP_RISE) ? (now & ~was) :
                 (f == tcc_pkg::CAP_FALL) ? (~now & was) :
                 (now ^ was);
   endfunction

   wire match_a = ~cap_a & (cnt_q == gra_q);          // see R16
   wire match_b = ~cap_b & (cnt_q == grb_q);          // see R16
   wire capt_a  = cap_a & cap_edge(func_a[1:0], PIN_A_IN, pa_q); // see R17
   wire capt_b  = cap_b & cap_edge(func_b[1:0], PIN_B_IN, pb_q); // see R17
   wire ev_a    = match_a | capt_a;
   wire ev_b    = match_b | capt_b;

   // Counter clear selection
   wire own_clear = ((clr_sel == tcc_pkg::CLR_A) & ev_a) |
                    ((clr_sel == tcc_pkg::CLR_B) & ev_b); // see R4 R5
   wire sync_sel  = (clr_sel == tcc_pkg::CLR_SYNC) & sync_en;
   wire do_clear  = own_clear | (sync_sel & SYNC_CLEAR_IN); // see R18
   assign SYNC_CLEAR_OUT = sync_en & own_clear;       // see R18

   // =========================================================
   // Counter: phase counting has precedence on channel 2
   wire up_tick = phase_mode ? PHASE_UP : src_tick;  // see R9 R1
   wire dn_tick = phase_mode & PHASE_DOWN;            // see R9
   always_ff @(posedge CLOCK) begin
      if (init)
         cnt_q <= tcc_pkg::CNT_RESET;
      else if (wr_cntl)
         cnt_q <= {cnt_q[15:8], WDATA};
      else if (wr_cnth)
         cnt_q <= {WDATA, cnt_q[7:0]};
      else if (do_clear)
         cnt_q <= tcc_pkg::CNT_RESET;                 // see R4
      else if (up_tick & ~dn_tick)
         cnt_q <= cnt_q + 16'h0001;
      else if (dn_tick & ~up_tick)
         cnt_q <= cnt_q - 16'h0001;
   end

   // General registers: capture wins over a software write
   always_ff @(posedge CLOCK) begin
      if (init) begin
         gra_q <= tcc_pkg::GR_RESET;
         grb_q <= tcc_pkg::GR_RESET;
      end else begin
         if (capt_a)
            gra_q <= cnt_q;                           // see R17
         else if (wr_gral)
            gra_q <= {gra_q[15:8], WDATA};
         else if (wr_grah)
            gra_q <= {WDATA, gra_q[7:0]};
         if (capt_b)
            grb_q <= cnt_q;                           // see R17
         else if (wr_grbl)
            grb_q <= {grb_q[15:8], WDATA};
         else if (wr_grbh)
            grb_q <= {WDATA, grb_q[7:0]};
      end
   end

   // =========================================================
   // Compare output pins
   function automatic logic pin_next(input logic [2:0] f,
                                     input logic cur);
      case (f[1:0])
         tcc_pkg::OUT_LOW:  pin_next = 1'b0;
         tcc_pkg::OUT_HIGH: pin_next = 1'b1;
         tcc_pkg::OUT_TGL:  pin_next = (CHANNEL == 2) ? 1'b1
                                                      : ~cur; // see R14
         default:           pin_next = cur;
      endcase
   endfunction

   logic outa_q, outb_q;
   always_ff @(posedge CLOCK) begin
      if (init) begin
         outa_q <= 1'b0;                              // see R13
         outb_q <= 1'b0;                              // see R13
      end else begin
         if (match_a)
            outa_q <= pin_next(func_a, outa_q);       // see R12
         if (match_b)
            outb_q <= pin_next(func_b, outb_q);       // see R11
      end
   end

   // Pin drives only in compare mode with an output action
   assign PIN_A_OUT  = outa_q;
   assign PIN_A_OE_N = cap_a | (func_a[1:0] == tcc_pkg::OUT_NONE);
   assign PIN_B_OUT  = outb_q;
   assign PIN_B_OE_N = cap_b | (func_b[1:0] == tcc_pkg::OUT_NONE);

   // =========================================================
   // Event status and interrupt: set wins over clear
   wire [1:0] ev_set = {ev_b, ev_a};
   always_ff @(posedge CLOCK) begin
      if (init) begin
         stat_q <= 2'h0;
         ien_q  <= 2'h0;
      end else begin
         stat_q <= ev_set | (stat_q & ~(wr_clr ? WDATA[1:0] : 2'h0));
         if (wr_ien)
            ien_q <= WDATA[1:0];
      end
   end

   assign IRQ = |(stat_q & ien_q);

   // =========================================================
   // Read data, one cycle after the strobe; unmapped reads zero
   logic [7:0] rd_mux;
   always_comb begin
      case (bus.addr)
         tcc_pkg::OFF_CCR:        rd_mux = ccr_q;
         tcc_pkg::OFF_PIN:        rd_mux = pin_q;
         tcc_pkg::OFF_GRA:        rd_mux = gra_q[7:0];
         tcc_pkg::OFF_GRA + 4'h1: rd_mux = gra_q[15:8];
         tcc_pkg::OFF_GRB:        rd_mux = grb_q[7:0];
         tcc_pkg::OFF_GRB + 4'h1: rd_mux = grb_q[15:8];
         tcc_pkg::OFF_CNT:        rd_mux = cnt_q[7:0];
         tcc_pkg::OFF_CNT + 4'h1: rd_mux = cnt_q[15:8];
         tcc_pkg::OFF_STAT:       rd_mux = {6'h00, stat_q};
         tcc_pkg::OFF_IEN:        rd_mux = {6'h00, ien_q};
         tcc_pkg::OFF_MODE:       rd_mux = {5'h00, mode_q};
         default:                 rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N)
         rdata_q <= 8'h00;
      else
         rdata_q <= bus.rd ? rd_mux : 8'h00;
   end

   assign RDATA = rdata_q;

endmodule

// ---- tb/tcc_channel_properties.sv ----
// Port-level checks for the timer channel control block
`timescale 1ns/100ps
module tcc_channel_properties (
   // Clock and reset
   input wire logic       CLOCK,
   input wire logic       RST_N,
   input wire logic       STANDBY,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // Pins and interrupt
   input wire logic       PIN_A_OUT,
   input wire logic       PIN_A_OE_N,
   input wire logic       PIN_B_OE_N,
   input wire logic       IRQ
);
   // ==========================================================
   // Register read-back
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   AST_CCR_RSV: assert property (
      RD && ADDR == tcc_pkg::OFF_CCR |=> RDATA[7])
      else $error("clock control bit 7 reads 0");
   AST_PIN_RSV: assert property (
      RD && ADDR == tcc_pkg::OFF_PIN |=> RDATA[7] && RDATA[3])
      else $error("pin control reserved bit reads 0");
   AST_CCR_WRITE: assert property (
      WR && !STANDBY && ADDR == tcc_pkg::OFF_CCR ##1 !WR && !STANDBY
      ##1 RD && !STANDBY && ADDR == tcc_pkg::OFF_CCR
      |=> RDATA == ($past(WDATA, 3) | tcc_pkg::CCR_FIXED))
      else $error("clock control read-back differs");
   AST_STBY_CCR: assert property (
      STANDBY ##1 !STANDBY && !WR ##1 RD && ADDR == tcc_pkg::OFF_CCR
      |=> RDATA == tcc_pkg::CCR_RESET)
      else $error("clock control not initialised");
   // ==========================================================
   // Pin drivers
   AST_STBY_OUT: assert property (
      STANDBY |=> !PIN_A_OUT && PIN_A_OE_N && PIN_B_OE_N && !IRQ)
      else $error("pins not initialised");
   AST_OE_DRIVE: assert property (
      WR && !STANDBY && ADDR == tcc_pkg::OFF_PIN && !WDATA[2]
      && WDATA[1:0] != 2'h0 |=> !PIN_A_OE_N)
      else $error("first pin not driven");
   AST_OE_CAP: assert property (
      WR && !STANDBY && ADDR == tcc_pkg::OFF_PIN && WDATA[6]
      |=> PIN_B_OE_N)
      else $error("second pin driven in capture");
   AST_OE_HOLD: assert property (
      $past(RST_N) && !$past(STANDBY)
      && !($past(WR) && $past(ADDR) == tcc_pkg::OFF_PIN)
      |-> $stable(PIN_A_OE_N))
      else $error("first pin enable moved");
endmodule

bind tcc_channel tcc_channel_properties u_props (.CLOCK(CLOCK),
   .RST_N(RST_N), .STANDBY(STANDBY), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_A_OUT(PIN_A_OUT),
   .PIN_A_OE_N(PIN_A_OE_N), .PIN_B_OE_N(PIN_B_OE_N), .IRQ(IRQ));

// ---- tb/tcc_pins_model.sv ----
// Far-side model: external clock pins and capture inputs
`timescale 1ns/100ps
module tcc_pins_model (
   // Clock
   input  wire logic       clk,
   // Design pin drivers
   input  wire logic       a_out,
   input  wire logic       a_oe_n,
   input  wire logic       b_out,
   input  wire logic       b_oe_n,
   // Levels seen by the design
   output logic      [3:0] ext_clk,
   output logic            a_in,
   output logic            b_in
);
   // ==========================================================
   // Pin levels: the design wins while its enable is low
   logic a_drv = 1'b0;
   logic b_drv = 1'b0;
   assign a_in = a_oe_n ? a_drv : a_out;
   assign b_in = b_oe_n ? b_drv : b_out;
   initial ext_clk = 4'h0;
   // Burst on the first clock pin; pins stand still between bursts
   task pulse(input int n);
      repeat (n) begin
         @(posedge clk) ext_clk[0] <= 1'b1;
         repeat (2) @(posedge clk);
         ext_clk[0] <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // New level on the second capture input, then settle time
   task set_b(input logic v);
      @(posedge clk) b_drv <= v;
      repeat (3) @(posedge clk);
   endtask
endmodule

// ---- tb/tcc_channel_tb_top.sv ----
// Self-checking testbench for the timer channel control block
`timescale 1ns/100ps
module tcc_channel_tb_top;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              stby = 1'b0;
   logic              phu = 1'b0;
   logic              phd = 1'b0;
   logic              syi = 1'b0;
   logic              syo;
   tcc_pkg::tcc_bus_t bus = '0;
   logic        [7:0] rdata, rv, a;
   logic        [3:0] ext;
   logic              pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n, irq;
   int                fails = 0;
   int                n_tests = 0;
   // Design on channel 2 and the far-side model
   tcc_channel #(.CHANNEL(2)) DUT (.CLOCK(clk), .RST_N(rst_n),
      .STANDBY(stby), .ADDR(bus.addr), .WDATA(bus.wdata), .WR(bus.wr),
      .RD(bus.rd), .RDATA(rdata), .EXT_CLK(ext), .PHASE_UP(phu),
      .PHASE_DOWN(phd), .SYNC_CLEAR_IN(syi), .SYNC_CLEAR_OUT(syo),
      .PIN_A_IN(pa_i), .PIN_A_OUT(pa_o), .PIN_A_OE_N(pa_oe_n),
      .PIN_B_IN(pb_i), .PIN_B_OUT(pb_o), .PIN_B_OE_N(pb_oe_n), .IRQ(irq));
   tcc_pins_model u_pins (.clk(clk), .a_out(pa_o), .a_oe_n(pa_oe_n),
      .b_out(pb_o), .b_oe_n(pb_oe_n), .ext_clk(ext), .a_in(pa_i),
      .b_in(pb_i));
   // ==========================================================
   // Bus cycles, comparison and verdict
   task end_sim;
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk) bus <= '{ad, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '{ad, d, 1'b0, 1'b0};
   endtask
   task rd(input logic [3:0] ad);
      @(posedge clk) bus <= '{ad, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '{ad, 8'h00, 1'b0, 1'b0};
      @(negedge clk) rv = rdata;
   endtask
   task rdc(input logic [3:0] ad, input logic [7:0] e);
      rd(ad);
      check(rv, e);
   endtask
   // Bounded wait for the first pin level; a timeout ends the run
   task wait_a(input logic v);
      for (int i = 0; i < 40 && pa_o !== v; i++) @(negedge clk);
      check(8'(pa_o), 8'(v));
      if (pa_o !== v) end_sim();
   endtask
   // ==========================================================
   // Reset values, reserved bits, unmapped places
   task t_regs;
      rdc(tcc_pkg::OFF_CCR, 8'h80);
      rdc(tcc_pkg::OFF_PIN, 8'h88);
      rdc(tcc_pkg::OFF_CLR, 8'h00);
      rdc(4'hf, 8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(tcc_pkg::OFF_CCR, i ? 8'h77 : 8'h00);
         rdc(tcc_pkg::OFF_CCR, i ? 8'hf7 : 8'h80);
         wr(tcc_pkg::OFF_PIN, i ? 8'h77 : 8'h00);
         rdc(tcc_pkg::OFF_PIN, i ? 8'hff : 8'h88);
      end
   endtask
   // Prescaler, phase mode, external source and edge choice
   task t_clock;
      for (int p = 0; p < 9; p++) begin
         wr(tcc_pkg::OFF_MODE, 8'(p == 4));
         wr(tcc_pkg::OFF_CCR, p < 5 ? 8'(p & 3) : p < 8
            ? 8'h04 | 8'((p - 5) << 3) : 8'h05);
         rd(tcc_pkg::OFF_CNT);
         a = rv;
         if (p < 5) repeat (62) @(posedge clk);
         else u_pins.pulse(4);
         rd(tcc_pkg::OFF_CNT);
         check(rv - a, p < 4 ? 8'(64 >> p) : p == 7 ? 8'h08
            : p == 5 || p == 6 ? 8'h04 : 8'h00);
      end
   endtask
   // Compare output, clear by first register, interrupt
   task t_compare;
      wr(tcc_pkg::OFF_CNT, 8'h00);
      wr(tcc_pkg::OFF_GRA, 8'h05);
      wr(tcc_pkg::OFF_GRA + 4'h1, 8'h00);
      wr(tcc_pkg::OFF_PIN, 8'h02);
      wr(tcc_pkg::OFF_IEN, 8'h01);
      wr(tcc_pkg::OFF_CCR, 8'h20);
      wait_a(1'b1);
      rd(tcc_pkg::OFF_CNT);
      check(8'(rv <= 8'h05), 8'h01);
      rdc(tcc_pkg::OFF_STAT, 8'h01);
      check(8'(irq), 8'h01);
      wr(tcc_pkg::OFF_IEN, 8'h00);
      @(negedge clk) check(8'(irq), 8'h00);
      wr(tcc_pkg::OFF_IEN, 8'h01);
      wr(tcc_pkg::OFF_PIN, 8'h01);
      wait_a(1'b0);
      wr(tcc_pkg::OFF_PIN, 8'h03);
      wait_a(1'b1);
      repeat (3) begin
         repeat (3) @(negedge clk);
         check(8'(pa_o), 8'h01);
      end
      wr(tcc_pkg::OFF_GRA, 8'hff);
      wr(tcc_pkg::OFF_CCR, 8'h04);
      wr(tcc_pkg::OFF_CLR, 8'h03);
      @(negedge clk) check(8'(irq), 8'h00);
   endtask
   // Capture on rising, then falling only
   task t_capture;
      wr(tcc_pkg::OFF_PIN, 8'h40);
      wr(tcc_pkg::OFF_CNT, 8'h5a);
      u_pins.set_b(1'b1);
      rdc(tcc_pkg::OFF_GRB, 8'h5a);
      rdc(tcc_pkg::OFF_STAT, 8'h02);
      wr(tcc_pkg::OFF_PIN, 8'h50);
      wr(tcc_pkg::OFF_CNT, 8'h33);
      u_pins.set_b(1'b0);
      wr(tcc_pkg::OFF_CNT, 8'h44);
      u_pins.set_b(1'b1);
      rdc(tcc_pkg::OFF_GRB, 8'h33);
   endtask
   // Sync group: own clear is announced, group request clears
   task t_sync;
      wr(tcc_pkg::OFF_MODE, 8'h04);
      wr(tcc_pkg::OFF_GRA, 8'h07);
      wr(tcc_pkg::OFF_CNT, 8'h07);
      wr(tcc_pkg::OFF_CCR, 8'h24);
      @(negedge clk) check(8'(syo), 8'h01);
      wr(tcc_pkg::OFF_CNT, 8'h21);
      wr(tcc_pkg::OFF_CCR, 8'h64);
      @(posedge clk) syi <= 1'b1;
      @(posedge clk) syi <= 1'b0;
      rdc(tcc_pkg::OFF_CNT, 8'h00);
   endtask
   // Standby initialises both control registers and the first pin output
   task t_standby;
      wr(tcc_pkg::OFF_CCR, 8'h25);
      wr(tcc_pkg::OFF_PIN, 8'h12);
      @(posedge clk) stby <= 1'b1;
      @(posedge clk) stby <= 1'b0;
      rdc(tcc_pkg::OFF_CCR, 8'h80);
      rdc(tcc_pkg::OFF_PIN, 8'h88);
      check(8'(pa_o), 8'h00);
   endtask
   // Clock, reset and main sequence
   always #2.5 clk = ~clk;
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_clock();
      t_compare();
      t_capture();
      t_sync();
      t_standby();
      end_sim();
   end
endmodule
